// file: rtl/crciu_unit.sv
`timescale 1ns/10ps
`default_nettype none
module crciu_unit (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_issue_valid,
	output logic o_issue_ready,
	input wire logic [31:0] i_insn,
	input wire logic [63:0] i_rs_value,
	input wire logic [63:0] i_rt_value,
	output logic o_done,
	output logic o_wr_en,
	output logic o_ri_exc,
	output logic [4:0] o_wr_idx,
	output logic [63:0] o_wr_data,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_RESP = 3'b100
	} crciu_state_e;

	crciu_state_e state_r, state_nxt;
	logic [4:0] idx_r, idx_nxt;
	logic [63:0] data_r, data_nxt;
	logic wr_r, wr_nxt;
	logic exc_r, exc_nxt;
	logic foreign_r, foreign_nxt;
	logic [1:0] ctrl_r, ctrl_nxt;
	logic [31:0] count_r, count_nxt;
	logic [31:0] last_r, last_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	logic dec_claim, dec_exc;
	logic [3:0] dec_nbytes;
	logic [4:0] dec_rt_idx;
	logic take;
	logic apb_setup, apb_write;

	crciu_eng_if eng_bus();

	// Keep only the selected low bytes; upper bytes read as zero
	function automatic logic [63:0] zero_fill(input logic [63:0] msg, input logic [3:0] nbytes);
		logic [63:0] m;
		m = 64'h0000_0000_0000_0000;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(nbytes)) begin
				m[i*8 +: 8] = msg[i*8 +: 8];
			end
		end
		return m;
	endfunction

	crciu_decode u_decode (
		.i_insn(i_insn),
		.i_feature_en(ctrl_r[crciu_pkg::CRCIU_CTRL_FEAT_BIT]),
		.i_en64(ctrl_r[crciu_pkg::CRCIU_CTRL_EN64_BIT]),
		.o_claim(dec_claim),
		.o_ri_exc(dec_exc),
		.o_nbytes(dec_nbytes),
		.o_rt_idx(dec_rt_idx)
	);

	crciu_engine u_engine (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.eng(eng_bus)
	);

	// Issue handshake; a trapped or foreign instruction never starts the engine
	assign o_issue_ready = (state_r == ST_IDLE);
	assign take = i_issue_valid && o_issue_ready;
	assign eng_bus.start = take && dec_claim && !dec_exc;
	assign eng_bus.crc_in = i_rt_value[31:0];
	assign eng_bus.msg = zero_fill(i_rs_value, dec_nbytes);
	assign eng_bus.nbytes = dec_nbytes;

	// Instruction sequencing and result capture
	always_comb begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		data_nxt = data_r;
		wr_nxt = wr_r;
		exc_nxt = exc_r;
		foreign_nxt = foreign_r;
		count_nxt = count_r;
		last_nxt = last_r;
		unique case (state_r)
			ST_IDLE: begin
				if (take) begin
					idx_nxt = dec_rt_idx;
					wr_nxt = 1'b0;
					exc_nxt = dec_exc;
					foreign_nxt = !dec_claim;
					if (eng_bus.start) begin
						state_nxt = ST_RUN;
					end else begin
						state_nxt = ST_RESP; // Destination left alone on a trap
					end
				end
			end
			ST_RUN: begin
				if (eng_bus.done) begin
					data_nxt = {{32{eng_bus.crc_out[31]}}, eng_bus.crc_out};
					wr_nxt = 1'b1;
					last_nxt = eng_bus.crc_out;
					count_nxt = count_r + 32'h0000_0001;
					state_nxt = ST_RESP;
				end
			end
			ST_RESP: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_r <= ST_IDLE;
			idx_r <= 5'h00;
			data_r <= 64'h0000_0000_0000_0000;
			wr_r <= 1'b0;
			exc_r <= 1'b0;
			foreign_r <= 1'b0;
			count_r <= 32'h0000_0000;
			last_r <= 32'h0000_0000;
		end else begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			data_r <= data_nxt;
			wr_r <= wr_nxt;
			exc_r <= exc_nxt;
			foreign_r <= foreign_nxt;
			count_r <= count_nxt;
			last_r <= last_nxt;
		end
	end

	// Done, write and trap flags stand for the single response cycle only; index and data are held
	assign o_done = (state_r == ST_RESP);
	assign o_wr_en = o_done && wr_r;
	assign o_ri_exc = o_done && exc_r;
	assign o_wr_idx = idx_r;
	assign o_wr_data = data_r;

	// APB slave: read data latched in setup so access completes with no wait
	assign apb_setup = i_psel && !i_penable;
	assign apb_write = i_psel && i_penable && i_pwrite;

	always_comb begin
		ctrl_nxt = ctrl_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (apb_write && (i_paddr == crciu_pkg::CRCIU_OFS_CTRL)) begin
			ctrl_nxt = i_pwdata[1:0];
		end
		if (apb_setup) begin
			prdata_nxt = 32'h0000_0000;
			pslverr_nxt = 1'b0;
			unique case (i_paddr)
				crciu_pkg::CRCIU_OFS_CTRL: prdata_nxt = {30'h0000_0000, ctrl_r};
				crciu_pkg::CRCIU_OFS_STATUS: begin
					prdata_nxt[crciu_pkg::CRCIU_STAT_BUSY_BIT] = (state_r != ST_IDLE);
					prdata_nxt[crciu_pkg::CRCIU_STAT_EXC_BIT] = exc_r;
					prdata_nxt[crciu_pkg::CRCIU_STAT_FOREIGN_BIT] = foreign_r;
				end
				crciu_pkg::CRCIU_OFS_COUNT: prdata_nxt = count_r;
				crciu_pkg::CRCIU_OFS_LAST: prdata_nxt = last_r;
				default: pslverr_nxt = 1'b1; // Unmapped address
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctrl_r <= crciu_pkg::CRCIU_CTRL_RST;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign o_pready = i_psel && i_penable;
	assign o_prdata = prdata_r;
	assign o_pslverr = o_pready && pslverr_r;
endmodule
`default_nettype wire

// file: rtl/crciu_pkg.sv
package crciu_pkg;
	// Reflected generator, degree-32 term left implicit
	localparam logic [31:0] CRCIU_POLY = 32'hedb8_8320;
	// Instruction encoding
	localparam logic [5:0] CRCIU_OPC_MAJOR = 6'h1f;
	localparam logic [5:0] CRCIU_FUNCT = 6'h0f;
	localparam logic [2:0] CRCIU_VARIANT = 3'h0;
	localparam logic [4:0] CRCIU_ZERO_FIELD = 5'h00;
	localparam int CRCIU_OPC_LSB = 26;
	localparam int CRCIU_RS_LSB = 21;
	localparam int CRCIU_RT_LSB = 16;
	localparam int CRCIU_ZERO_LSB = 11;
	localparam int CRCIU_VAR_LSB = 8;
	localparam int CRCIU_SZ_LSB = 6;
	localparam int CRCIU_FUNCT_LSB = 0;
	// Message size codes
	localparam logic [1:0] CRCIU_SZ_BYTE = 2'h0;
	localparam logic [1:0] CRCIU_SZ_HALF = 2'h1;
	localparam logic [1:0] CRCIU_SZ_WORD = 2'h2;
	localparam logic [1:0] CRCIU_SZ_DWORD = 2'h3;
	localparam logic [3:0] CRCIU_NB_BYTE = 4'h1;
	localparam logic [3:0] CRCIU_NB_HALF = 4'h2;
	localparam logic [3:0] CRCIU_NB_WORD = 4'h4;
	localparam logic [3:0] CRCIU_NB_DWORD = 4'h8;
	// Register map, byte addresses
	localparam logic [11:0] CRCIU_OFS_CTRL = 12'h000;
	localparam logic [11:0] CRCIU_OFS_STATUS = 12'h004;
	localparam logic [11:0] CRCIU_OFS_COUNT = 12'h008;
	localparam logic [11:0] CRCIU_OFS_LAST = 12'h00c;
	// Control fields
	localparam int CRCIU_CTRL_FEAT_BIT = 0;
	localparam int CRCIU_CTRL_EN64_BIT = 1;
	localparam logic [1:0] CRCIU_CTRL_RST = 2'h3;
	// Status fields
	localparam int CRCIU_STAT_BUSY_BIT = 0;
	localparam int CRCIU_STAT_EXC_BIT = 1;
	localparam int CRCIU_STAT_FOREIGN_BIT = 2;
endpackage

// file: rtl/crciu_eng_if.sv
`timescale 1ns/10ps
`default_nettype none
interface crciu_eng_if;
	logic start;
	logic [31:0] crc_in;
	logic [63:0] msg;
	logic [3:0] nbytes;
	logic busy;
	logic done;
	logic [31:0] crc_out;
	modport ctl(output start, output crc_in, output msg, output nbytes, input busy, input done, input crc_out);
	modport eng(input start, input crc_in, input msg, input nbytes, output busy, output done, output crc_out);
endinterface
`default_nettype wire

// file: rtl/crciu_decode.sv
`timescale 1ns/10ps
`default_nettype none
module crciu_decode (
	input wire logic [31:0] i_insn,
	input wire logic i_feature_en,
	input wire logic i_en64,
	output logic o_claim,
	output logic o_ri_exc,
	output logic [3:0] o_nbytes,
	output logic [4:0] o_rt_idx
);
	logic [1:0] message_size_field;

	// Family match: major group, function code, zero gap and variant bits
	always_comb begin
		message_size_field = i_insn[crciu_pkg::CRCIU_SZ_LSB +: 2];
		o_rt_idx = i_insn[crciu_pkg::CRCIU_RT_LSB +: 5];
		o_claim = (i_insn[crciu_pkg::CRCIU_OPC_LSB +: 6] == crciu_pkg::CRCIU_OPC_MAJOR) &&
			(i_insn[crciu_pkg::CRCIU_FUNCT_LSB +: 6] == crciu_pkg::CRCIU_FUNCT) &&
			(i_insn[crciu_pkg::CRCIU_ZERO_LSB +: 5] == crciu_pkg::CRCIU_ZERO_FIELD) &&
			(i_insn[crciu_pkg::CRCIU_VAR_LSB +: 3] == crciu_pkg::CRCIU_VARIANT);
		o_nbytes = crciu_pkg::CRCIU_NB_BYTE;
		o_ri_exc = 1'b0;
		unique case (message_size_field)
			crciu_pkg::CRCIU_SZ_BYTE: o_nbytes = crciu_pkg::CRCIU_NB_BYTE;
			crciu_pkg::CRCIU_SZ_HALF: o_nbytes = crciu_pkg::CRCIU_NB_HALF;
			crciu_pkg::CRCIU_SZ_WORD: o_nbytes = crciu_pkg::CRCIU_NB_WORD;
			crciu_pkg::CRCIU_SZ_DWORD: begin
				o_nbytes = crciu_pkg::CRCIU_NB_DWORD;
				o_ri_exc = !i_en64;
			end
		endcase
		// Only the two enables can trap; operand values never do
		if (!i_feature_en) begin
			o_ri_exc = 1'b1;
		end
		o_ri_exc = o_ri_exc && o_claim;
	end
endmodule
`default_nettype wire

// file: rtl/crciu_engine.sv
`timescale 1ns/10ps
`default_nettype none
module crciu_engine (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	crciu_eng_if.eng eng
);
	logic [31:0] crc_r, crc_nxt;
	logic [63:0] msg_r, msg_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic done_r, done_nxt;

	// Eight shift-and-reduce steps for one byte, lsb is the top coefficient
	function automatic logic [31:0] byte_step(input logic [31:0] crc, input logic [7:0] data);
		logic [31:0] v;
		v = crc ^ {24'h00_0000, data};
		for (int i = 0; i < 8; i++) begin
			if (v[0]) begin
				v = (v >> 1) ^ crciu_pkg::CRCIU_POLY;
			end else begin
				v = v >> 1;
			end
		end
		return v;
	endfunction

	// One byte per cycle, low byte first; equal to the wide bit-serial form
	always_comb begin
		crc_nxt = crc_r;
		msg_nxt = msg_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (eng.start) begin
			crc_nxt = eng.crc_in;
			msg_nxt = eng.msg;
			cnt_nxt = eng.nbytes;
		end else if (cnt_r != 4'h0) begin
			crc_nxt = byte_step(crc_r, msg_r[7:0]);
			msg_nxt = {8'h00, msg_r[63:8]};
			cnt_nxt = cnt_r - 4'h1;
			done_nxt = (cnt_r == 4'h1);
		end
	end

	// State registers only
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			crc_r <= 32'h0000_0000;
			msg_r <= 64'h0000_0000_0000_0000;
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			crc_r <= crc_nxt;
			msg_r <= msg_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign eng.busy = (cnt_r != 4'h0);
	assign eng.done = done_r;
	assign eng.crc_out = crc_r;
endmodule
`default_nettype wire

// file: dv/crciu_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
// Pipeline stand-in: offers one instruction and holds it until the unit takes it
module crciu_pipe_model (
	input wire logic i_clk,
	input wire logic i_ready,
	input wire logic i_done,
	output logic o_valid,
	output logic [31:0] o_insn,
	output logic [63:0] o_rs,
	output logic [63:0] o_rt
);
	initial begin
		o_valid = 1'b0;
		o_insn = '0;
		o_rs = '0;
		o_rt = '0;
	end
	// Operands are inverted once taken, so a unit that samples late reads junk
	// No cycle count is assumed for either wait; a hang is left to the bench timeout
	task automatic issue(input logic [31:0] insn, input logic [63:0] rs, input logic [63:0] rt);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_insn <= insn;
		o_rs <= rs;
		o_rt <= rt;
		do begin
			@(posedge i_clk);
		end while (i_ready !== 1'b1);
		o_valid <= 1'b0;
		o_insn <= ~insn;
		o_rs <= ~rs;
		o_rt <= ~rt;
		do begin
			@(posedge i_clk);
		end while (i_done !== 1'b1);
	endtask
endmodule
`default_nettype wire

// file: dv/crciu_unit_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module crciu_unit_assertions (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_issue_valid,
	input wire logic o_issue_ready,
	input wire logic [31:0] i_insn,
	input wire logic o_done,
	input wire logic o_wr_en,
	input wire logic o_ri_exc,
	input wire logic [4:0] o_wr_idx,
	input wire logic [63:0] o_wr_data
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic [31:0] held_r;
	wire take = i_issue_valid && o_issue_ready;
	wire ours = i_insn[31:26] == crciu_pkg::CRCIU_OPC_MAJOR && i_insn[5:0] == crciu_pkg::CRCIU_FUNCT
		&& i_insn[15:8] == 8'h00;
	// Keep the taken word so the answer can be tied to its own destination
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			held_r <= '0;
		else if (take)
			held_r <= i_insn;
	end
	// Answer shapes: a trap comes next cycle, a result after n+2
	sequence s_trap;
		##1 o_done && o_ri_exc && !o_wr_en;
	endsequence
	sequence s_byte;
		##3 o_done && o_wr_en;
	endsequence
	sequence s_dword;
		##10 o_done && o_wr_en;
	endsequence
	chk_take_busy: assert property (take |=> !o_issue_ready)
		else $error("ready stayed high after take");
	chk_done_pulse: assert property (o_done |=> !o_done)
		else $error("done longer than one cycle");
	chk_exc_alone: assert property (o_wr_en || o_ri_exc |-> o_done && !(o_wr_en && o_ri_exc))
		else $error("write and trap not exclusive");
	chk_byte_time: assert property (take && ours && i_insn[7:6] == 2'h0 |-> s_trap or s_byte)
		else $error("byte answer late or wrong");
	chk_dword_time: assert property (take && ours && i_insn[7:6] == 2'h3 |-> s_trap or s_dword)
		else $error("dword answer late or wrong");
	chk_foreign_quiet: assert property (take && !ours |=> o_done && !o_wr_en && !o_ri_exc)
		else $error("foreign word acted on");
	chk_sign_ext: assert property (o_wr_en |-> o_wr_data[63:32] == {32{o_wr_data[31]}})
		else $error("result not sign extended");
	chk_dest_idx: assert property (o_wr_en |-> o_wr_idx == held_r[20:16])
		else $error("wrong destination");
endmodule
bind crciu_unit crciu_unit_assertions u_chk (
	.i_clk(i_clk),
	.i_sys_rst(i_sys_rst),
	.i_issue_valid(i_issue_valid),
	.o_issue_ready(o_issue_ready),
	.i_insn(i_insn),
	.o_done(o_done),
	.o_wr_en(o_wr_en),
	.o_ri_exc(o_ri_exc),
	.o_wr_idx(o_wr_idx),
	.o_wr_data(o_wr_data)
);
`default_nettype wire

// file: dv/crciu_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module crciu_unit_tb;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic valid, ready, done, wr_en, ri_exc, pready, pslverr, e;
	logic [31:0] insn, prdata, q, last;
	logic [63:0] rs, rt, wr_data;
	logic [4:0] wr_idx;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #12.5 i_clk = ~i_clk;
	crciu_pipe_model PM (.i_clk(i_clk), .i_ready(ready), .i_done(done), .o_valid(valid), .o_insn(insn),
		.o_rs(rs), .o_rt(rt));
	crciu_unit DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_issue_valid(valid), .o_issue_ready(ready),
		.i_insn(insn), .i_rs_value(rs), .i_rt_value(rt), .o_done(done), .o_wr_en(wr_en), .o_ri_exc(ri_exc),
		.o_wr_idx(wr_idx), .o_wr_data(wr_data), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));
	// Bit-serial reference, independent of the engine's byte-wide form
	function automatic logic [63:0] crc_ref(logic [31:0] v, logic [63:0] m, int nb);
		logic [63:0] x;
		x = {32'h0000_0000, v} ^ (m & ((64'h1 << (nb * 8)) - 1));
		for (int i = 0; i < nb * 8; i++)
			x = x[0] ? (x >> 1) ^ crciu_pkg::CRCIU_POLY : x >> 1;
		return {{32{x[31]}}, x[31:0]};
	endfunction
	function automatic logic [31:0] ins(input logic [1:0] sz);
		return {crciu_pkg::CRCIU_OPC_MAJOR, 5'h03, 5'h07, 8'h00, sz, crciu_pkg::CRCIU_FUNCT};
	endfunction
	// One APB transfer; the request stands until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
		output logic re);
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		// No wait count is assumed; only the bench timeout ends a stuck access
		do begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
		apb(1'b0, a, '0, q, e);
		`CHK(q, exp)
		`CHK(e, eerr)
	endtask
	// Issue one word and judge the answer; fix flips encoding bits
	task automatic op(input logic [1:0] sz, input logic [31:0] fix, input logic [63:0] m, input logic [31:0] v,
		input logic ew, input logic ex);
		logic [63:0] exp;
		exp = crc_ref(v, m, 1 << sz);
		PM.issue(ins(sz) ^ fix, m, {32'h5a5a_5a5a, v});
		`CHK(wr_en, ew)
		`CHK(ri_exc, ex)
		if (ew) begin
			`CHK(wr_data, exp)
			`CHK(wr_idx, 5'h07)
			last = exp[31:0];
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, far beyond the roughly 120 cycles the tests need
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			final_report;
		end
	end
	initial begin
		repeat (20) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		rd(crciu_pkg::CRCIU_OFS_CTRL, 32'h0000_0003, 1'b0);
		rd(12'h010, 32'h0000_0000, 1'b1);
		$display("test reset_regs ended");
		// Every size chained through the destination; upper message bytes must not count
		last = 32'hffff_ffff;
		for (int s = 0; s < 4; s++)
			op(s[1:0], '0, 64'hc3a5_0f96_1e2d_3c4b, last, 1'b1, 1'b0);
		apb(1'b1, crciu_pkg::CRCIU_OFS_LAST, '0, q, e);
		rd(crciu_pkg::CRCIU_OFS_LAST, last, 1'b0);
		rd(crciu_pkg::CRCIU_OFS_COUNT, 32'h0000_0004, 1'b0);
		$display("test sizes ended");
		// 64-bit off: only the eight-byte form traps
		apb(1'b1, crciu_pkg::CRCIU_OFS_CTRL, 32'h0000_0001, q, e);
		op(2'h3, '0, '1, last, 1'b0, 1'b1);
		op(2'h2, '0, '1, last, 1'b1, 1'b0);
		// Feature off: the whole family traps whatever the operands
		apb(1'b1, crciu_pkg::CRCIU_OFS_CTRL, 32'h0000_0002, q, e);
		for (int s = 0; s < 4; s++)
			op(s[1:0], '0, '0, '1, 1'b0, 1'b1);
		rd(crciu_pkg::CRCIU_OFS_STATUS, 32'h0000_0002, 1'b0);
		$display("test traps ended");
		// Wrong function code, then nonzero variant bits: neither written nor trapped
		apb(1'b1, crciu_pkg::CRCIU_OFS_CTRL, 32'h0000_0003, q, e);
		op(2'h0, 32'h0000_0001, '1, last, 1'b0, 1'b0);
		op(2'h0, 32'h0000_0100, '1, last, 1'b0, 1'b0);
		// Nonzero gap field and a wrong major group must be passed over too
		op(2'h0, 32'h0000_0800, '1, last, 1'b0, 1'b0);
		op(2'h0, 32'h0400_0000, '1, last, 1'b0, 1'b0);
		rd(crciu_pkg::CRCIU_OFS_STATUS, 32'h0000_0004, 1'b0);
		$display("test foreign ended");
		final_report;
	end
endmodule
`default_nettype wire
